// >>> logic/mcb_defines.svh
// constants for the multi-cycle channel bus port
//Contract
//- channel enable chains through every device in order
//- channel request only while incoming enable true
//- requesting immediately breaks the outgoing channel enable
//- channel request raised only on sync pulse
//- during channel grant drive word-count address
//- priority request only with enable; breaks chain
//- nearest device on the priority chain wins
//- priority request raised only on sync pulse
//- during priority grant drive trap address
//- system clear pulse returns all state initial; the code loads prev_sync from the synchronised sync level instead
//- inhibit stops current-address increment during transfers
//- write request asks for word from memory
//- read request offers a word to memory
//- program interrupt traps to location 000000
//- skip request returned during first control pulse
`ifndef MCB_DEFINES_SVH
`define MCB_DEFINES_SVH
`define MCB_DATA_W 18
`define MCB_ADDR_W 4
`define MCB_SYNC_STAGES 2
`define MCB_WC_ADDR 4'h6
`endif

// >>> logic/mcb_pkg.sv
// types for the multi-cycle channel bus port
`include "mcb_defines.svh"
package mcb_pkg;
	// channel transfer sequence
	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_PEND = 2'b01,
		CH_REQ = 2'b10,
		CH_XFER = 2'b11
	} mcb_ch_state_t;
	// priority-interrupt sequence
	typedef enum logic [1:0] {
		PI_IDLE = 2'b00,
		PI_PEND = 2'b01,
		PI_REQ = 2'b10,
		PI_GRANT = 2'b11
	} mcb_pi_state_t;
	// bus levels arriving from the processor
	typedef struct packed {
		logic chan_en;
		logic chan_gr;
		logic prio_en;
		logic prio_gr;
		logic io_sync;
		logic sys_clr;
		logic pulse1;
		logic pulse2;
		logic pulse3;
		logic wc_oflo;
		logic [`MCB_DATA_W-1:0] data;
	} mcb_bus_in_t;
	// whole state of the port
	typedef struct packed {
		mcb_ch_state_t ch;
		mcb_pi_state_t pi;
		logic prev_sync;
		logic prev_p2;
		logic prev_p3;
		logic prev_oflo;
		logic seen2;
		logic seen3;
		logic ch_req_n;
		logic ch_en_out;
		logic pi_req_n;
		logic pi_en_out;
		logic rd_req_n;
		logic wr_req_n;
		logic inh_n;
		logic prog_int_n;
		logic skip_n;
		logic [`MCB_ADDR_W-1:0] addr;
		logic addr_oe;
		logic [`MCB_DATA_W-1:0] data;
		logic data_oe;
		logic [`MCB_DATA_W-1:0] rx;
		logic rx_valid;
		logic oflo_flag;
	} mcb_state_t;
	// initial state: all low-active bus lines released
	function automatic mcb_state_t mcb_init_state();
		mcb_state_t s;
		s = '0;
		s.ch_req_n = 1'b1;
		s.pi_req_n = 1'b1;
		s.rd_req_n = 1'b1;
		s.wr_req_n = 1'b1;
		s.inh_n = 1'b1;
		s.prog_int_n = 1'b1;
		s.skip_n = 1'b1;
		return s;
	endfunction : mcb_init_state
endpackage : mcb_pkg

// >>> logic/mcb_sync.sv
// two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module mcb_sync #(
	parameter int W = 1
) (
	input wire logic clk_in, // port clock
	input wire logic nrst_in, // async reset, active low
	input wire logic ce_in, // clock enable
	input wire logic [W-1:0] d_in, // asynchronous levels
	output logic [W-1:0] q_out // synchronised levels
);
	logic [W-1:0] meta; // first stage, read only by q_out
	// two flops; the first is never looked at by logic
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta <= '0;
			q_out <= '0;
		end else if (ce_in) begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule : mcb_sync

// >>> logic/mcb_port.sv
// device-side port logic for the multi-cycle channel bus
`timescale 1ns/1ps
`include "mcb_defines.svh"
module mcb_port #(
	parameter logic [`MCB_ADDR_W-1:0] WC_ADDR = `MCB_WC_ADDR
) (
	input wire logic clk_in, // 25 MHz port clock
	input wire logic nrst_in, // async reset, active low
	input wire logic ce_in, // clock enable, freezes all state
	input wire logic channel_chain_enable_in, // channel enable from upstream
	input wire logic channel_grant_in, // channel grant
	input wire logic prio_level_enable_in, // priority enable from upstream
	input wire logic prio_level_grant_in, // priority grant
	input wire logic io_sync_in, // processor sync pulse
	input wire logic system_clear_pulse_in, // bus-wide clear
	input wire logic control_pulse_first_in, // first control pulse
	input wire logic control_pulse_second_in, // second control pulse
	input wire logic control_pulse_third_in, // third control pulse
	input wire logic word_count_overflow_in, // word count overflow pulse
	input wire logic [`MCB_DATA_W-1:0] io_data_in, // bus data lines
	input wire logic xfer_start_in, // user: start one channel transfer
	input wire logic mode_read_in, // user: offer a word to memory
	input wire logic mode_write_in, // user: take a word from memory
	input wire logic inhibit_in, // user: hold current address
	input wire logic [`MCB_DATA_W-1:0] tx_data_in, // user: word to offer
	input wire logic prio_start_in, // user: post a priority request
	input wire logic [`MCB_ADDR_W-1:0] trap_addr_in, // user: trap address
	input wire logic oflo_to_prio_in, // user: overflow raises priority request
	input wire logic oflo_clear_in, // user: clear overflow flag
	input wire logic prog_int_in, // user: program interrupt level
	input wire logic selected_in, // user: device selected by test instr
	input wire logic skip_cond_in, // user: tested condition holds
	output logic channel_request_n_out, // channel request, active low
	output logic channel_chain_enable_out, // channel enable to downstream
	output logic prio_level_request_n_out, // priority request, active low
	output logic prio_level_enable_out, // priority enable to downstream
	output logic to_memory_request_n_out, // read request, active low
	output logic from_memory_request_n_out, // write request, active low
	output logic addr_increment_inhibit_n_out, // address inhibit, active low
	output logic program_interrupt_request_n_out, // program interrupt, low
	output logic skip_request_n_out, // skip request, active low
	output logic [`MCB_ADDR_W-1:0] io_addr_out, // address lines value
	output logic io_addr_oe_out, // address lines driven
	output logic [`MCB_DATA_W-1:0] io_data_out, // bus data value
	output logic io_data_oe_out, // bus data driven
	output logic [`MCB_DATA_W-1:0] rx_data_out, // word taken from memory
	output logic rx_valid_out, // one-cycle pulse with rx_data_out
	output logic oflo_flag_out // sticky overflow flag
);
	import mcb_pkg::*;
	mcb_bus_in_t raw; // pins gathered
	mcb_bus_in_t b; // pins after synchroniser
	mcb_state_t st; // registered state
	mcb_state_t next_st; // next state
	logic sync_edge; // rising edge of sync pulse
	logic oflo_edge; // rising edge of overflow pulse

	// gather pins into the carrier
	always_comb begin
		raw = '{chan_en: channel_chain_enable_in, chan_gr: channel_grant_in,
			prio_en: prio_level_enable_in, prio_gr: prio_level_grant_in,
			io_sync: io_sync_in, sys_clr: system_clear_pulse_in,
			pulse1: control_pulse_first_in, pulse2: control_pulse_second_in,
			pulse3: control_pulse_third_in, wc_oflo: word_count_overflow_in,
			data: io_data_in};
	end

	// every bus pin crosses two flops before use
	mcb_sync #(.W($bits(mcb_bus_in_t))) u_sync (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.d_in(raw),
		.q_out(b)
	);

	assign sync_edge = b.io_sync & ~st.prev_sync; // timing base
	assign oflo_edge = b.wc_oflo & ~st.prev_oflo;

	// next-state logic for the whole port
	always_comb begin
		next_st = st;
		next_st.prev_sync = b.io_sync;
		next_st.prev_p2 = b.pulse2;
		next_st.prev_p3 = b.pulse3;
		next_st.prev_oflo = b.wc_oflo;
		next_st.rx_valid = 1'b0;
		// overflow flag: a new pulse wins over a clear
		next_st.oflo_flag = (st.oflo_flag & ~oflo_clear_in) | oflo_edge;
		next_st.prog_int_n = ~(prog_int_in | (st.oflo_flag & ~oflo_to_prio_in));
		next_st.skip_n = ~(b.pulse1 & selected_in & skip_cond_in);
		// address lines stand only while a grant stands, even once the channel side is idle
		if (!b.chan_gr && st.addr_oe && st.pi != PI_GRANT) begin
			next_st.addr_oe = 1'b0;
		end
		// channel sequence
		case (st.ch)
			CH_IDLE: begin
				next_st.ch_en_out = b.chan_en; // pass enable on
				if (xfer_start_in) begin
					next_st.ch = CH_PEND;
				end
			end
			CH_PEND: begin
				next_st.ch_en_out = b.chan_en;
				if (sync_edge && b.chan_en) begin
					next_st.ch_req_n = 1'b0;
					next_st.ch_en_out = 1'b0; // cut off downstream
					next_st.ch = CH_REQ;
				end
			end
			CH_REQ: begin
				if (b.chan_gr) begin // grant taken
					next_st.ch_req_n = 1'b1;
					next_st.addr = WC_ADDR;
					next_st.addr_oe = 1'b1;
					next_st.inh_n = ~inhibit_in;
					next_st.rd_req_n = ~mode_read_in;
					next_st.wr_req_n = ~mode_write_in;
					next_st.seen2 = 1'b0;
					next_st.seen3 = 1'b0;
					next_st.ch = CH_XFER;
				end
			end
			default: begin
				// data word placed on the rising second pulse
				if (b.pulse2 && !st.prev_p2 && !st.rd_req_n) begin
					next_st.data = tx_data_in;
					next_st.data_oe = 1'b1;
					next_st.seen2 = 1'b1;
				end else if (!b.pulse2) begin
					next_st.data_oe = 1'b0;
				end
				if (b.pulse3 && !st.prev_p3 && !st.wr_req_n) begin
					next_st.rx = b.data;
					next_st.rx_valid = 1'b1;
					next_st.seen3 = 1'b1;
				end
				// both halves done, release requests, inhibit, data lines and chain enable
				if ((st.seen2 || st.rd_req_n) && (st.seen3 || st.wr_req_n) && !b.pulse2) begin
					next_st.rd_req_n = 1'b1;
					next_st.wr_req_n = 1'b1;
					next_st.inh_n = 1'b1;
					next_st.data_oe = 1'b0;
					next_st.ch_en_out = b.chan_en;
					next_st.ch = CH_IDLE;
				end
			end
		endcase
		// priority-interrupt sequence
		case (st.pi)
			PI_IDLE: begin
				next_st.pi_en_out = b.prio_en;
				if (prio_start_in || (oflo_edge && oflo_to_prio_in)) begin
					next_st.pi = PI_PEND;
				end
			end
			PI_PEND: begin
				next_st.pi_en_out = b.prio_en;
				if (sync_edge && b.prio_en) begin
					next_st.pi_req_n = 1'b0;
					next_st.pi_en_out = 1'b0;
					next_st.pi = PI_REQ;
				end
			end
			PI_REQ: begin
				if (b.prio_gr) begin
					next_st.pi_req_n = 1'b1;
					next_st.addr = trap_addr_in;
					next_st.addr_oe = 1'b1;
					next_st.pi = PI_GRANT;
				end
			end
			default: begin
				if (!b.prio_gr) begin
					next_st.addr_oe = 1'b0;
					next_st.pi_en_out = b.prio_en;
					next_st.pi = PI_IDLE;
				end
			end
		endcase
		// bus clear wins over everything
		if (b.sys_clr) begin
			next_st = mcb_init_state();
			next_st.prev_sync = b.io_sync;
		end
	end

	// state register, frozen while ce_in is low
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= mcb_init_state();
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	// outputs straight from the state flops
	assign channel_request_n_out = st.ch_req_n;
	assign channel_chain_enable_out = st.ch_en_out;
	assign prio_level_request_n_out = st.pi_req_n;
	assign prio_level_enable_out = st.pi_en_out;
	assign to_memory_request_n_out = st.rd_req_n;
	assign from_memory_request_n_out = st.wr_req_n;
	assign addr_increment_inhibit_n_out = st.inh_n;
	assign program_interrupt_request_n_out = st.prog_int_n;
	assign skip_request_n_out = st.skip_n;
	assign io_addr_out = st.addr;
	assign io_addr_oe_out = st.addr_oe;
	assign io_data_out = st.data;
	assign io_data_oe_out = st.data_oe;
	assign rx_data_out = st.rx;
	assign rx_valid_out = st.rx_valid;
	assign oflo_flag_out = st.oflo_flag;

	// checks beside the logic
	ch_req_enable_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$fell(st.ch_req_n) |-> $past(b.chan_en) && $past(sync_edge))
		else $error("channel request without enable or sync");
	ch_chain_cut_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!st.ch_req_n |-> !st.ch_en_out)
		else $error("channel enable passed while requesting");
	pi_req_sync_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$fell(st.pi_req_n) |-> $past(sync_edge))
		else $error("priority request off the sync pulse");
	pi_chain_cut_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$fell(st.pi_req_n) |-> $past(b.prio_en) && !st.pi_en_out)
		else $error("priority request without enable or chain not cut");
	wc_addr_drive_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && st.ch == CH_REQ && b.chan_gr && !b.sys_clr) |=> st.addr_oe && st.addr == WC_ADDR)
		else $error("word count address not driven on grant");
	trap_addr_drive_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && st.pi == PI_REQ && b.prio_gr && !b.sys_clr)
		|=> st.addr_oe && st.addr == $past(trap_addr_in))
		else $error("trap address not driven on grant");
	sys_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ce_in && b.sys_clr) |=> st.ch == CH_IDLE && st.pi == PI_IDLE && st.ch_req_n && !st.addr_oe)
		else $error("clear pulse did not reset port");
	rdwr_in_xfer_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!st.rd_req_n || !st.wr_req_n || !st.inh_n) |-> st.ch == CH_XFER)
		else $error("transfer request outside transfer");
	skip_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!st.skip_n |-> $past(b.pulse1) && $past(skip_cond_in))
		else $error("skip request outside first control pulse");
	release_done_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(st.ch == CH_IDLE && $past(st.ch) == CH_XFER)
		|-> st.ch_req_n && st.rd_req_n && st.wr_req_n && st.inh_n)
		else $error("transfer ended without releasing lines");
endmodule : mcb_port

// >>> dv/mcb_proc_model.sv
// behavioural model of the processor side of the channel bus
`timescale 1ns/1ps
`include "mcb_defines.svh"
module mcb_proc_model (
	input wire logic clk_in, // bus clock for pulse timing
	input wire logic ch_req_n_in, // channel request, active low
	input wire logic pi_req_n_in, // priority request, active low
	input wire logic to_mem_n_in, // read request, active low
	input wire logic from_mem_n_in, // write request, active low
	input wire logic inh_n_in, // address inhibit, active low
	input wire logic [`MCB_ADDR_W-1:0] addr_in, // address lines from device
	input wire logic [`MCB_DATA_W-1:0] data_in, // data lines from device
	input wire logic oflo_cmd_in, // pulse overflow on next transfer
	input wire logic [`MCB_DATA_W-1:0] wdata_in, // word sent out of memory
	output logic sync_out, // sync pulse train
	output logic ch_gr_out, // channel grant
	output logic pi_gr_out, // priority grant
	output logic p2_out, // second control pulse
	output logic p3_out, // third control pulse
	output logic oflo_out, // word count overflow pulse
	output logic [`MCB_DATA_W-1:0] data_out, // data lines to device
	output logic [`MCB_ADDR_W-1:0] got_addr_out, // address seen at channel grant
	output logic [`MCB_ADDR_W-1:0] got_trap_out, // address seen at priority grant
	output logic [`MCB_DATA_W-1:0] got_word_out, // word taken on second pulse
	output logic got_rd_n_out, // read request seen
	output logic got_wr_n_out, // write request seen
	output logic got_inh_n_out, // inhibit seen
	output int n_chan_out, // channel transfers served
	output int n_prio_out // priority breaks served
);
	// free-running sync, one microsecond apart, 250 ns high
	initial begin
		sync_out = 1'b0;
		#13;
		forever begin
			sync_out = 1'b1;
			#250;
			sync_out = 1'b0;
			#750;
		end
	end
	// channel service: grant, then the pulses that the requests ask for
	initial begin
		{ch_gr_out, p2_out, p3_out, oflo_out, n_chan_out} = '0;
		data_out = 18'h3C3C3;
		forever begin
			@(posedge clk_in);
			if (ch_req_n_in === 1'b0) begin
				repeat (6) @(posedge clk_in);
				ch_gr_out <= 1'b1;
				repeat (8) @(posedge clk_in);
				got_addr_out <= addr_in;
				got_rd_n_out <= to_mem_n_in;
				got_wr_n_out <= from_mem_n_in;
				got_inh_n_out <= inh_n_in;
				oflo_out <= oflo_cmd_in;
				repeat (6) @(posedge clk_in);
				oflo_out <= 1'b0;
				// word into memory: device places it during the pulse
				if (to_mem_n_in === 1'b0) begin
					p2_out <= 1'b1;
					repeat (6) @(posedge clk_in);
					got_word_out <= data_in;
					p2_out <= 1'b0;
				end
				// word out of memory: data valid around the pulse only
				if (from_mem_n_in === 1'b0) begin
					data_out <= wdata_in;
					p3_out <= 1'b1;
					repeat (6) @(posedge clk_in);
					p3_out <= 1'b0;
					repeat (3) @(posedge clk_in);
					data_out <= ~wdata_in;
				end
				repeat (4) @(posedge clk_in);
				ch_gr_out <= 1'b0;
				n_chan_out <= n_chan_out + 1;
			end
		end
	end
	// priority service: grant for a fixed span, address read meanwhile
	initial begin
		{pi_gr_out, n_prio_out} = '0;
		forever begin
			@(posedge clk_in);
			if (pi_req_n_in === 1'b0) begin
				repeat (5) @(posedge clk_in);
				pi_gr_out <= 1'b1;
				repeat (8) @(posedge clk_in);
				got_trap_out <= addr_in;
				pi_gr_out <= 1'b0;
				n_prio_out <= n_prio_out + 1;
			end
		end
	end
endmodule : mcb_proc_model

// >>> dv/mcb_port_test.sv
// self-checking bench for the channel bus port
`timescale 1ns/1ps
`include "mcb_defines.svh"
module mcb_port_test;
	logic clk_in, nrst_in, ch_en, pi_en, clr, p1, start, rd, wr, inh, pst, sel, cnd, ocmd;
	logic otp, ocl, pint;
	logic sync, ch_gr, pi_gr, p2, p3, ofl, crq_n, ceo, prq_n, peo, tm_n, fm_n, inh_n, pin_n;
	logic sk_n, aoe, doe, rxv, oflag, grd, gwr, ginh;
	logic [17:0] txd, wdat, pdat, gword, dout, rxd, lastrx;
	logic [3:0] trap, addr, gaddr, gtrap;
	int n_errors, check_count, age, nc, np;
	// stimulus defaults
	initial begin
		{nrst_in, clr, p1, start, rd, wr, inh, pst, sel, cnd, ocmd} = '0;
		{otp, ocl, pint} = '0;
		{ch_en, pi_en} = 2'b11;
		txd = 18'h2A5C3;
		wdat = 18'h15A3C;
		trap = 4'h9;
	end
	// 25 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// cycles since sync was last seen high, last received word
	always @(posedge clk_in) begin
		age <= sync ? 0 : age + 1;
		if (rxv === 1'b1) lastrx <= rxd;
	end
	mcb_port DUT (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
		.channel_chain_enable_in(ch_en), .channel_grant_in(ch_gr), .prio_level_enable_in(pi_en),
		.prio_level_grant_in(pi_gr), .io_sync_in(sync), .system_clear_pulse_in(clr),
		.control_pulse_first_in(p1), .control_pulse_second_in(p2), .control_pulse_third_in(p3),
		.word_count_overflow_in(ofl), .io_data_in(pdat), .xfer_start_in(start), .mode_read_in(rd),
		.mode_write_in(wr), .inhibit_in(inh), .tx_data_in(txd), .prio_start_in(pst),
		.trap_addr_in(trap), .oflo_to_prio_in(otp), .oflo_clear_in(ocl), .prog_int_in(pint),
		.selected_in(sel), .skip_cond_in(cnd), .channel_request_n_out(crq_n),
		.channel_chain_enable_out(ceo), .prio_level_request_n_out(prq_n),
		.prio_level_enable_out(peo), .to_memory_request_n_out(tm_n),
		.from_memory_request_n_out(fm_n), .addr_increment_inhibit_n_out(inh_n),
		.program_interrupt_request_n_out(pin_n), .skip_request_n_out(sk_n), .io_addr_out(addr),
		.io_addr_oe_out(aoe), .io_data_out(dout), .io_data_oe_out(doe), .rx_data_out(rxd),
		.rx_valid_out(rxv), .oflo_flag_out(oflag));
	mcb_proc_model PM (.clk_in(clk_in), .ch_req_n_in(crq_n), .pi_req_n_in(prq_n),
		.to_mem_n_in(tm_n), .from_mem_n_in(fm_n), .inh_n_in(inh_n), .addr_in(addr),
		.data_in(dout), .oflo_cmd_in(ocmd), .wdata_in(wdat), .sync_out(sync), .ch_gr_out(ch_gr),
		.pi_gr_out(pi_gr), .p2_out(p2), .p3_out(p3), .oflo_out(ofl), .data_out(pdat),
		.got_addr_out(gaddr), .got_trap_out(gtrap), .got_word_out(gword),
		.got_rd_n_out(grd), .got_wr_n_out(gwr),
		.got_inh_n_out(ginh), .n_chan_out(nc), .n_prio_out(np));
	// end of run: counts then verdict
	task print_verdict;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	task check_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
		end
	endtask : check_bit
	task check_word(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t word got %h expected %h", $time, got, exp);
		end
	endtask : check_word
	// bounded wait for a request line to go low, sampled on falling edges
	task automatic wait_low(ref logic s);
		for (int i = 0; i < 400 && s !== 1'b0; i++) @(negedge clk_in);
		check_bit(s, 1'b0);
	endtask : wait_low
	// bounded wait until the model has served one more request
	task automatic wait_served(ref int n, input int old);
		for (int i = 0; i < 400 && n == old; i++) @(negedge clk_in);
		check_bit(n != old, 1'b1);
		repeat (4) @(negedge clk_in);
	endtask : wait_served
	// one channel transfer with the checks common to every mode
	task do_chan(input logic r, input logic w, input logic i, input logic o);
		int old;
		old = nc;
		@(posedge clk_in);
		{rd, wr, inh, ocmd, start} <= {r, w, i, o, 1'b1};
		@(posedge clk_in);
		start <= 1'b0;
		wait_low(crq_n);
		check_bit(age < 3, 1'b1);
		check_bit(ceo, 1'b0);
		wait_served(nc, old);
		check_word({14'h0, gaddr}, {14'h0, `MCB_WC_ADDR});
		check_bit(grd, ~r);
		check_bit(gwr, ~w);
		check_bit(ginh, ~i);
		check_bit(ceo, 1'b1);
		check_bit(crq_n, 1'b1);
		check_bit(aoe, 1'b0);
		check_bit(doe, 1'b0);
	endtask : do_chan
	task t_read;
		do_chan(1'b1, 1'b0, 1'b1, 1'b0);
		check_word(gword, txd);
	endtask : t_read
	task t_write;
		do_chan(1'b0, 1'b1, 1'b0, 1'b0);
		check_word(lastrx, wdat);
	endtask : t_write
	// add-to-memory with word count overflow: flag raises program interrupt
	task t_add;
		do_chan(1'b1, 1'b1, 1'b0, 1'b1);
		check_bit(oflag, 1'b1);
		check_bit(pin_n, 1'b0);
	endtask : t_add
	// no request while the incoming enable is low
	task t_gate;
		@(posedge clk_in);
		{ch_en, rd, wr, start} <= 4'b0101;
		@(posedge clk_in);
		start <= 1'b0;
		repeat (60) @(negedge clk_in) check_bit(crq_n, 1'b1);
		check_bit(ceo, 1'b0);
		@(posedge clk_in) ch_en <= 1'b1;
		wait_low(crq_n);
		wait_served(nc, nc);
	endtask : t_gate
	task t_prio;
		@(posedge clk_in);
		pst <= 1'b1;
		@(posedge clk_in);
		pst <= 1'b0;
		wait_low(prq_n);
		check_bit(age < 3, 1'b1);
		check_bit(peo, 1'b0);
		wait_served(np, np);
		check_word({14'h0, gtrap}, {14'h0, trap});
		check_bit(peo, 1'b1);
		check_bit(aoe, 1'b0);
	endtask : t_prio
	// overflow routed away from, then level onto, the program interrupt; then flag clear
	task t_flags;
		@(posedge clk_in) otp <= 1'b1;
		repeat (2) @(negedge clk_in);
		check_bit(pin_n, 1'b1);
		@(posedge clk_in) {otp, pint} <= 2'b01;
		repeat (2) @(negedge clk_in);
		check_bit(pin_n, 1'b0);
		@(posedge clk_in) {pint, ocl} <= 2'b01;
		repeat (3) @(negedge clk_in);
		check_bit(oflag, 1'b0);
		check_bit(pin_n, 1'b1);
		@(posedge clk_in) ocl <= 1'b0;
	endtask : t_flags
	// skip answered only while the condition holds
	task t_skip;
		sel <= 1'b1;
		for (int c = 0; c < 2; c++) begin
			@(posedge clk_in);
			{cnd, p1} <= {c[0], 1'b1};
			repeat (5) @(posedge clk_in);
			@(negedge clk_in) check_bit(sk_n, ~c[0]);
			@(posedge clk_in) p1 <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
	endtask : t_skip
	// clear pulse drops a pending request and the overflow flag
	task t_clear;
		@(posedge clk_in);
		{pi_en, pst} <= 2'b01;
		@(posedge clk_in) pst <= 1'b0;
		@(posedge clk_in) clr <= 1'b1;
		repeat (6) @(posedge clk_in);
		clr <= 1'b0;
		repeat (4) @(posedge clk_in);
		pi_en <= 1'b1;
		repeat (60) @(negedge clk_in) check_bit(prq_n, 1'b1);
		check_bit(oflag, 1'b0);
	endtask : t_clear
	initial begin
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_skip;
		t_read;
		t_write;
		t_gate;
		t_prio;
		t_add;
		t_clear;
		t_add;
		t_flags;
		print_verdict;
	end
	// watchdog, well beyond the expected run
	initial begin
		#2000000;
		n_errors++;
		print_verdict;
	end
endmodule : mcb_port_test
